//--- rtl/tss_pkg.sv
// Constants and carrier types for the transfer switch sequencer.
// Assumes a single 100 MHz system clock.
`default_nettype none
package tss_pkg;
    // ********************
    // Clock and time base
    // ********************
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TICK_PERIOD_S = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
    localparam int unsigned TICK_W = 27;
    // ********************
    // Delays in seconds
    // ********************
    localparam int unsigned ENG_START_S = 3;
    localparam int unsigned TO_STANDBY_S = 2;
    localparam int unsigned TO_UTILITY_S = 12;
    localparam int unsigned COOLDOWN_MIN = 2;
    localparam int unsigned COOLDOWN_S = COOLDOWN_MIN * 60;
    localparam int unsigned EXER_MIN = 20;
    localparam int unsigned EXER_S = EXER_MIN * 60;
    localparam int unsigned WEEK_DAYS = 7;
    localparam int unsigned WEEK_S = WEEK_DAYS * 86400;
    localparam int unsigned HOLDUP_S = 90;
    localparam int unsigned DLY_W = 8;
    localparam int unsigned EXER_W = 11;
    localparam int unsigned WEEK_W = 20;
    localparam int unsigned HOLD_W = 7;
    // ********************
    // Sensing carrier
    // ********************
    localparam int unsigned PHASES = 3;
    typedef struct packed {
        logic [PHASES-1:0] above_pickup;
        logic [PHASES-1:0] below_dropout;
    } tss_src_sense_t;
    localparam int unsigned SYNC_W = 2 * $bits(tss_src_sense_t) + 2;
    typedef enum logic [2:0] {
        ST_NORMAL, ST_START_DLY, ST_WAIT_EMERG, ST_XFER_DLY,
        ST_ON_EMERG, ST_RETX_DLY, ST_COOLDOWN
    } tss_state_t;
endpackage
`default_nettype wire

//--- rtl/tss_transfer_controller.sv
// Transfer switch sequencer: source qualification, transfer delays,
// generator start/stop, load contactor command and weekly exerciser.
// Assumes comparator and selector inputs are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module tss_transfer_controller #(
    parameter int unsigned TICK_CYCLES = tss_pkg::TICK_CYCLES,
    parameter int unsigned WEEK_S = tss_pkg::WEEK_S,
    parameter int unsigned EXER_S = tss_pkg::EXER_S,
    parameter int unsigned HOLDUP_S = tss_pkg::HOLDUP_S
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Source voltage comparators
    input wire tss_pkg::tss_src_sense_t norm_sense,
    input wire tss_pkg::tss_src_sense_t emerg_sense,
    // Exerciser selector; run is neither set nor disable
    input wire logic sel_set,
    input wire logic sel_disable,
    // Generator and contactor commands, status
    output logic gen_start,
    output logic load_to_emerg,
    output logic exercising,
    output logic normal_ok,
    output logic emerg_ok
);
    // ********************
    // Input synchronisers
    // ********************
    logic [tss_pkg::SYNC_W-1:0] meta_ff;
    logic [tss_pkg::SYNC_W-1:0] sync_ff;
    tss_pkg::tss_src_sense_t norm_s;
    tss_pkg::tss_src_sense_t emerg_s;
    wire set_s;
    wire dis_s;
    assign {norm_s, emerg_s, set_s, dis_s} = sync_ff;

    always_ff @(posedge clk)
    begin
        meta_ff <= {norm_sense, emerg_sense, sel_set, sel_disable};
        sync_ff <= meta_ff;
    end

    // ********************
    // One second tick
    // ********************
    logic [tss_pkg::TICK_W-1:0] pre_ff;
    logic tick_ff;
    wire pre_end = pre_ff == tss_pkg::TICK_W'(TICK_CYCLES - 1);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pre_ff <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            pre_ff <= pre_end ? '0 : pre_ff + 1'b1;
            tick_ff <= pre_end;
        end
    end

    // ********************
    // Source qualification
    // ********************
    function automatic logic src_ok(input logic ok,
                                    input tss_pkg::tss_src_sense_t s);
        // Hysteresis: pickup needed to qualify, dropout to fail
        src_ok = !(|s.below_dropout) && (ok || (|s.above_pickup));
    endfunction

    logic norm_ok_ff;
    logic emerg_ok_ff;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            norm_ok_ff <= 1'b0;
            emerg_ok_ff <= 1'b0;
        end
        else
        begin
            norm_ok_ff <= src_ok(norm_ok_ff, norm_s);
            emerg_ok_ff <= src_ok(emerg_ok_ff, emerg_s);
        end
    end

    // ********************
    // Transfer sequencer
    // ********************
    tss_pkg::tss_state_t state_ff;
    tss_pkg::tss_state_t nxt_state;
    logic [tss_pkg::DLY_W-1:0] dly_ff;

    function automatic logic [tss_pkg::DLY_W-1:0] dly_limit(
        input tss_pkg::tss_state_t st);
        unique case (st)
            tss_pkg::ST_START_DLY:
                dly_limit = tss_pkg::DLY_W'(tss_pkg::ENG_START_S);
            tss_pkg::ST_XFER_DLY:
                dly_limit = tss_pkg::DLY_W'(tss_pkg::TO_STANDBY_S);
            tss_pkg::ST_RETX_DLY:
                dly_limit = tss_pkg::DLY_W'(tss_pkg::TO_UTILITY_S);
            tss_pkg::ST_COOLDOWN:
                dly_limit = tss_pkg::DLY_W'(tss_pkg::COOLDOWN_S);
            default:
                dly_limit = '1;
        endcase
    endfunction

    function automatic logic gen_state(input tss_pkg::tss_state_t st);
        gen_state = !(st inside {tss_pkg::ST_NORMAL, tss_pkg::ST_START_DLY});
    endfunction

    wire dly_done = tick_ff && (dly_ff == dly_limit(state_ff) - 1'b1);

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            tss_pkg::ST_NORMAL:
                if (!norm_ok_ff)
                    nxt_state = tss_pkg::ST_START_DLY;
            tss_pkg::ST_START_DLY:
                if (norm_ok_ff)
                    nxt_state = tss_pkg::ST_NORMAL;
                else if (dly_done)
                    nxt_state = tss_pkg::ST_WAIT_EMERG;
            tss_pkg::ST_WAIT_EMERG:
                if (norm_ok_ff)
                    nxt_state = tss_pkg::ST_COOLDOWN;
                else if (emerg_ok_ff)
                    nxt_state = tss_pkg::ST_XFER_DLY;
            tss_pkg::ST_XFER_DLY:
                if (norm_ok_ff)
                    nxt_state = tss_pkg::ST_COOLDOWN;
                else if (!emerg_ok_ff)
                    nxt_state = tss_pkg::ST_WAIT_EMERG;
                else if (dly_done)
                    nxt_state = tss_pkg::ST_ON_EMERG;
            tss_pkg::ST_ON_EMERG:
                if (norm_ok_ff)
                    nxt_state = tss_pkg::ST_RETX_DLY;
            tss_pkg::ST_RETX_DLY:
                if (!norm_ok_ff)
                    nxt_state = tss_pkg::ST_ON_EMERG;
                else if (dly_done)
                    nxt_state = tss_pkg::ST_COOLDOWN;
            tss_pkg::ST_COOLDOWN:
                // Engine still turning, so skip the start delay
                if (!norm_ok_ff)
                    nxt_state = tss_pkg::ST_WAIT_EMERG;
                else if (dly_done)
                    nxt_state = tss_pkg::ST_NORMAL;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_ff <= tss_pkg::ST_NORMAL;
            dly_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (nxt_state != state_ff)
                dly_ff <= '0;
            else if (tick_ff)
                dly_ff <= dly_ff + 1'b1;
        end
    end

    // ********************
    // Weekly exerciser
    // ********************
    logic [tss_pkg::WEEK_W-1:0] week_ff;
    logic [tss_pkg::EXER_W-1:0] exer_cnt_ff;
    logic [tss_pkg::HOLD_W-1:0] hold_ff;
    logic exer_ff;
    logic lost_ff;
    logic set_prev_ff;
    logic gen_start_ff;
    logic to_emerg_ff;

    wire set_rel = set_prev_ff && !set_s;
    wire both_dead = !norm_ok_ff && !emerg_ok_ff;
    wire relearn = lost_ff && !both_dead;
    wire week_wrap = tick_ff && week_ff == tss_pkg::WEEK_W'(WEEK_S - 1);
    wire hold_end = tick_ff && hold_ff == tss_pkg::HOLD_W'(HOLDUP_S - 1);
    wire exer_end = tick_ff && exer_cnt_ff == tss_pkg::EXER_W'(EXER_S - 1);
    // Weekly slot only fires in run and never while lost_ff is set; a set release still starts one
    wire exer_go = set_rel
        || (week_wrap && !dis_s && !set_s && !lost_ff);
    wire nxt_exer = exer_go ? !dis_s
        : (exer_ff && !dis_s && !exer_end);
    // Exercise only ORs into the start line, never into the contactor
    wire nxt_gen_start = gen_state(nxt_state) || nxt_exer;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            week_ff <= '0;
            exer_cnt_ff <= '0;
            hold_ff <= '0;
            exer_ff <= 1'b0;
            lost_ff <= 1'b0;
            set_prev_ff <= 1'b0;
        end
        else
        begin
            set_prev_ff <= set_s;
            if (set_rel || relearn || week_wrap)
                week_ff <= '0;
            else if (tick_ff)
                week_ff <= week_ff + 1'b1;
            exer_ff <= nxt_exer;
            if (!nxt_exer || exer_go)
                exer_cnt_ff <= '0;
            else if (tick_ff)
                exer_cnt_ff <= exer_cnt_ff + 1'b1;
            if (!both_dead)
                hold_ff <= '0;
            else if (tick_ff && !lost_ff)
                hold_ff <= hold_ff + 1'b1;
            if (relearn)
                lost_ff <= 1'b0;
            else if (both_dead && hold_end)
                lost_ff <= 1'b1;
        end
    end

    // ********************
    // Output registers
    // ********************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            gen_start_ff <= 1'b0;
            to_emerg_ff <= 1'b0;
        end
        else
        begin
            gen_start_ff <= nxt_gen_start;
            to_emerg_ff <= nxt_state inside
                {tss_pkg::ST_ON_EMERG, tss_pkg::ST_RETX_DLY};
        end
    end

    assign gen_start = gen_start_ff;
    assign load_to_emerg = to_emerg_ff;
    assign exercising = exer_ff;
    assign normal_ok = norm_ok_ff;
    assign emerg_ok = emerg_ok_ff;

    // ********************
    // Checks
    // ********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_FAIL_ANY_PHASE: assert property (
        |norm_s.below_dropout |=> !norm_ok_ff)
        else $error("normal not failed on dropout");
    AST_START_DLY_ENTRY: assert property (
        state_ff == tss_pkg::ST_NORMAL && !norm_ok_ff
        |=> state_ff == tss_pkg::ST_START_DLY && dly_ff == 0)
        else $error("start delay not begun");
    AST_NO_START_RESTORED: assert property (
        state_ff == tss_pkg::ST_START_DLY && norm_ok_ff
        |=> state_ff == tss_pkg::ST_NORMAL ##1 !gen_start_ff || exer_ff)
        else $error("start issued after restore");
    AST_START_AT_EXPIRY: assert property (
        state_ff == tss_pkg::ST_START_DLY && !norm_ok_ff && dly_done
        |=> gen_start_ff && state_ff == tss_pkg::ST_WAIT_EMERG)
        else $error("generator not started at expiry");
    AST_XFER_ONLY_AFTER_DLY: assert property (
        $rose(to_emerg_ff) |-> $past(state_ff) == tss_pkg::ST_XFER_DLY
        && $past(dly_done))
        else $error("transfer without standby delay");
    AST_RETX_RESET: assert property (
        state_ff == tss_pkg::ST_RETX_DLY && !norm_ok_ff
        |=> state_ff == tss_pkg::ST_ON_EMERG && to_emerg_ff && dly_ff == 0)
        else $error("utility delay not reset");
    AST_COOL_RUNS: assert property (
        (state_ff == tss_pkg::ST_COOLDOWN)[*2] |-> gen_start_ff
        && !to_emerg_ff)
        else $error("engine stopped in cooldown");
    AST_COOL_STOP: assert property (
        state_ff == tss_pkg::ST_COOLDOWN && norm_ok_ff && dly_done
        && !nxt_exer |=> !gen_start_ff)
        else $error("generator still commanded after cooldown");
    AST_EXER_NO_XFER: assert property (
        exer_ff && state_ff == tss_pkg::ST_NORMAL |-> gen_start_ff
        && !to_emerg_ff)
        else $error("exercise moved the load");
    AST_SET_RELEASE: assert property (
        set_rel && !dis_s |=> exer_ff && week_ff == 0 ##1 gen_start_ff)
        else $error("set release did not start exercise");
    AST_DISABLE_SUPPRESS: assert property (
        dis_s |=> !exer_ff)
        else $error("exercise while disabled");
    AST_RELEARN: assert property (
        relearn |=> week_ff == 0 && !lost_ff)
        else $error("week timer not re-set on return");

    COV_ON_EMERG: cover property (state_ff == tss_pkg::ST_ON_EMERG);
    COV_RETX: cover property (
        state_ff == tss_pkg::ST_RETX_DLY ##1 state_ff == tss_pkg::ST_COOLDOWN);
    COV_EXER: cover property ($rose(exer_ff));
    COV_LOST: cover property ($rose(lost_ff));
endmodule
`default_nettype wire

//--- tb/tss_genset_model.sv
// Behavioural generator set and load contactor.
// Assumes the sequencer's start and contactor commands as inputs.
`timescale 1ns/1ps
`default_nettype none
module tss_genset_model #(
    parameter int GEN_UP = 15
) (
    // Clock
    input wire logic clk,
    // Commands from the sequencer
    input wire logic gen_start,
    input wire logic load_to_emerg,
    // Engine fails to build voltage
    input wire logic gen_dead,
    // Generator sensing and contactor position
    output var tss_pkg::tss_src_sense_t emerg_sense,
    output var logic on_emerg
);
    int run_cnt = 0;
    always @(posedge clk)
    begin
        run_cnt <= (gen_start && !gen_dead) ? run_cnt + 1 : 0;
        on_emerg <= load_to_emerg;
    end
    // Stopped engine shows every phase below dropout, never a stale level
    assign emerg_sense = (run_cnt >= GEN_UP) ? 6'h38 : 6'h07;
endmodule
`default_nettype wire

//--- tb/tb_transfer_switch_sequencer.sv
// Self-checking bench for the transfer switch sequencer.
// Assumes tss_genset_model plays the generator set and contactor.
`timescale 1ns/1ps
`default_nettype none
module tb_transfer_switch_sequencer;
    // ******
    // Setup
    // ******
    localparam int TK = 10;
    localparam int WK = 400;
    localparam int EX = 20;
    localparam int HU = 5;
    localparam int WKC = WK * TK;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sel_set = 1'b0;
    logic sel_disable = 1'b0;
    logic gen_dead = 1'b0;
    logic gen_start, load_to_emerg, exercising, normal_ok, emerg_ok;
    logic on_emerg;
    tss_pkg::tss_src_sense_t norm_sense = 6'h38;
    tss_pkg::tss_src_sense_t emerg_sense;
    int num_errors = 0;
    int total_checks = 0;
    longint t0;
    int n;
    always #5 clk = ~clk;
    tss_transfer_controller #(.TICK_CYCLES(TK), .WEEK_S(WK), .EXER_S(EX),
        .HOLDUP_S(HU)) dut (.clk(clk), .rst(rst), .norm_sense(norm_sense),
        .emerg_sense(emerg_sense), .sel_set(sel_set),
        .sel_disable(sel_disable), .gen_start(gen_start),
        .load_to_emerg(load_to_emerg), .exercising(exercising),
        .normal_ok(normal_ok), .emerg_ok(emerg_ok));
    tss_genset_model #(.GEN_UP(15)) gen (.clk(clk), .gen_start(gen_start),
        .load_to_emerg(load_to_emerg), .gen_dead(gen_dead),
        .emerg_sense(emerg_sense), .on_emerg(on_emerg));
    // ******
    // Helpers
    // ******
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return gen_start;
            1: return load_to_emerg;
            2: return exercising;
            default: return normal_ok;
        endcase
    endfunction
    function automatic logic near(input longint a, input longint b);
        return (a - b <= 12) && (b - a <= 12);
    endfunction
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wait_for(input int w, input logic v, input int mx);
        n = 0;
        while (pick(w) !== v && n < mx)
        begin
            step(1);
            n++;
        end
        if (pick(w) !== v)
            chk("wait_limit", pick(w), v);
    endtask
    task automatic hold(input string nm, input int w, input logic v,
        input int k);
        logic ok;
        ok = 1'b1;
        repeat (k)
        begin
            step(1);
            if (pick(w) !== v) ok = 1'b0;
        end
        chk(nm, ok, 1'b1);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ******
    // Scenarios
    // ******
    task automatic t_blip();
        norm_sense = 6'h00;
        hold("hyst_keep", 3, 1'b1, 10);
        norm_sense = 6'h2A;
        wait_for(3, 1'b0, 10);
        chk("fail_lat", n, 3);
        norm_sense = 6'h00;
        hold("no_pickup", 3, 1'b0, 8);
        norm_sense = 6'h08;
        wait_for(3, 1'b1, 10);
        chk("restore_lat", n, 3);
        hold("no_start", 0, 1'b0, 60);
        $display("t_blip done");
    endtask
    task automatic t_outage();
        norm_sense = 6'h07;
        wait_for(0, 1'b1, 60);
        chk("start_lat", n >= 24 && n <= 37, 1'b1);
        wait_for(1, 1'b1, 100);
        chk("xfer_lat", n >= 28 && n <= 42, 1'b1);
        chk("emerg_acc", emerg_ok, 1'b1);
        hold("stay_emerg", 1, 1'b1, 50);
        norm_sense = 6'h38;
        step(50);
        norm_sense = 6'h07;
        hold("retx_reset", 1, 1'b1, 130);
        norm_sense = 6'h38;
        wait_for(1, 1'b0, 200);
        chk("retx_lat", n >= 110 && n <= 128, 1'b1);
        chk("cool_run", gen_start, 1'b1);
        wait_for(0, 1'b0, 1400);
        chk("cool_lat", n >= 1188 && n <= 1206, 1'b1);
        chk("contactor", on_emerg, 1'b0);
        $display("t_outage done");
    endtask
    task automatic t_exer();
        sel_set = 1'b1;
        step(4);
        sel_set = 1'b0;
        wait_for(2, 1'b1, 6);
        chk("set_lat", n, 3);
        t0 = $time;
        step(1);
        chk("exer_gen", gen_start, 1'b1);
        hold("no_xfer", 1, 1'b0, EX * TK - 12);
        wait_for(2, 1'b0, 30);
        chk("exer_len", near(($time - t0) / 10, EX * TK), 1'b1);
        wait_for(2, 1'b1, WKC);
        chk("week1", near(($time - t0) / 10, WKC), 1'b1);
        sel_disable = 1'b1;
        wait_for(2, 1'b0, 6);
        chk("dis_stop", n >= 2 && n <= 4, 1'b1);
        hold("dis_skip", 2, 1'b0, WKC);
        sel_disable = 1'b0;
        wait_for(2, 1'b1, WKC);
        chk("week3", near(($time - t0) / 10, 3 * WKC), 1'b1);
        $display("t_exer done");
    endtask
    task automatic t_prio();
        norm_sense = 6'h07;
        wait_for(1, 1'b1, 100);
        chk("prio_xfer", n >= 35 && n <= 60, 1'b1);
        norm_sense = 6'h38;
        wait_for(1, 1'b0, 200);
        chk("prio_back", n >= 110 && n <= 128, 1'b1);
        wait_for(0, 1'b0, 1400);
        chk("prio_cool", n >= 1188 && n <= 1206, 1'b1);
        $display("t_prio done");
    endtask
    task automatic t_holdup();
        gen_dead = 1'b1;
        norm_sense = 6'h07;
        step((HU - 2) * TK);
        chk("emerg_dead", emerg_ok, 1'b0);
        norm_sense = 6'h38;
        wait_for(0, 1'b0, 1400);
        gen_dead = 1'b0;
        wait_for(2, 1'b1, WKC);
        chk("hold_keep", near(($time - t0) / 10, 4 * WKC), 1'b1);
        wait_for(2, 1'b0, 300);
        gen_dead = 1'b1;
        norm_sense = 6'h07;
        step((HU + 3) * TK);
        norm_sense = 6'h38;
        t0 = $time;
        wait_for(0, 1'b0, 1400);
        gen_dead = 1'b0;
        wait_for(2, 1'b1, WKC + 20);
        chk("relearn", near(($time - t0) / 10, WKC), 1'b1);
        $display("t_holdup done");
    endtask
    // ******
    // Sequence and watchdog
    // ******
    initial
    begin
        step(2);
        rst = 1'b0;
        step(10);
        t_blip();
        t_outage();
        t_exer();
        t_prio();
        t_holdup();
        tally_and_finish();
    end
    // Whole sequence needs about 22000 cycles
    initial
    begin
        repeat (40000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
